// [src/hrp_proc_end.sv]
// hrp_proc_end: processor end of a root port or chipset link
// assumes: far end joined through hrp_link_if.proc; core side is same-clock
//
// Behaviour
// RULE1: train x16, fall back to x8/x4/x2/x1
// RULE2: three rates chosen during training
// RULE3: 8b/10b low rates, 128b/130b top
// RULE4: 4 KB config space, extended from 100h
// RULE5: memory-mapped config becomes config cycle
// RULE6: software uses aligned 32-bit config accesses
// RULE7: downstream address bits 63:36 zero
// RULE8: upstream read above 64 GB gets UR
// RULE9: upstream write above 64 GB dropped
// RULE10: reissue config cycle on retry status
// RULE11: forward peer posted writes only, VC0
// RULE12: link trains by itself after reset
// RULE13: polarity inversion and static lane reversal (lane reversal forced off on the chipset link)
// RULE14: no hot-plug logic
// RULE15: chipset link x4 at gen2 only
// RULE16: core accepts only VLW, reset-warn, MSI
// RULE17: send SMI, SCI, SERR downstream
// RULE18: legacy hold request and acknowledge
// RULE19: link errors reported only as SERR
// RULE20: link SERR attributed to device 0
// RULE21: hub blocks retrain after link down
// RULE22: no completions upstream after link down
`default_nettype none
module hrp_proc_end #(
   parameter bit IS_CHIPSET = 1'b0
) (
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   // link
   hrp_link_if.proc         lnk,
   // straps
   input  wire logic [15:0] pol_inv_i,
   input  wire logic        lane_rev_i,
   // core request
   input  wire logic        req_valid_i,
   input  wire logic        req_cfg_i,
   input  wire logic [63:0] req_addr_i,
   input  wire logic [31:0] req_data_i,
   output logic             req_ready_o,
   // core completion
   output logic             cpl_valid_o,
   output logic [1:0]       cpl_status_o,
   output logic [31:0]      cpl_data_o,
   // upstream delivery
   output logic             core_valid_o,
   output logic [2:0]       core_type_o,
   output logic [63:0]      core_addr_o,
   output logic [31:0]      core_data_o,
   output logic [1:0]       core_dst_o,
   // errors and sideband
   input  wire logic        smi_i,
   input  wire logic        sci_i,
   input  wire logic        link_err_i,
   input  wire logic        hold_grant_i,
   output logic             hold_req_o,
   output logic             link_down_o,
   output logic             coding_130_o
);
   typedef enum logic [1:0] {
      HRP_S_IDLE,
      HRP_S_SEND,
      HRP_S_WAIT
   } hrp_dn_state_t;

   hrp_dn_state_t st;
   logic          cfg_q;
   logic [63:0]   addr_q;
   logic [31:0]   data_q;
   logic          up_w;
   logic [4:0]    w_w;
   logic [1:0]    r_w;
   logic          dropped;
   logic          up_acc;
   logic          up_above;

   function automatic logic above_limit(input logic [63:0] a);
      above_limit = |a[63:hrp_pkg::LIMIT_LSB];
   endfunction

   // RULE15 chipset link offers x4 gen2, trained down to the far end's width and rate
   hrp_trainer u_train (
      .core_clk_i      (core_clk_i),
      .rst_i           (rst_i),
      .own_width_i     (IS_CHIPSET ? hrp_pkg::CS_LINK_WIDTH
                                   : hrp_pkg::WIDTH_X16),
      .own_rate_i      (IS_CHIPSET ? hrp_pkg::CS_LINK_RATE
                                   : 2'(hrp_pkg::HRP_RATE_G3)),
      .far_width_i     (lnk.far_width),
      .far_rate_i      (lnk.far_rate),
      .retrain_block_i (IS_CHIPSET),
      .drop_i          (link_err_i & IS_CHIPSET),
      .up_o            (up_w),
      .width_o         (w_w),
      .rate_o          (r_w)
   );

   // RULE13 polarity inversion, lane reversal in root port mode only
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         lnk.rx_pol_inv <= 16'h0000;
         lnk.lane_rev   <= 1'b0;
         lnk.link_up    <= 1'b0;
         lnk.neg_width  <= 5'h00;
         lnk.neg_rate   <= 2'h0;
         coding_130_o   <= 1'b0;
      end else begin
         lnk.rx_pol_inv <= pol_inv_i;
         lnk.lane_rev   <= lane_rev_i & ~IS_CHIPSET;
         lnk.link_up    <= up_w;
         lnk.neg_width  <= w_w;
         lnk.neg_rate   <= r_w;
         // RULE3 coding by rate
         coding_130_o   <= (r_w == 2'(hrp_pkg::HRP_RATE_G3));
      end
   end

   // RULE22 link down is sticky
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         dropped <= 1'b0;
      end else if (IS_CHIPSET && lnk.link_up && !up_w) begin
         dropped <= 1'b1;
      end
   end
   assign link_down_o = dropped;

   // RULE5 RULE10 downstream request engine
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         st          <= HRP_S_IDLE;
         cfg_q       <= 1'b0;
         addr_q      <= 64'h0;
         data_q      <= 32'h0;
         req_ready_o <= 1'b0;
         cpl_valid_o <= 1'b0;
         cpl_status_o <= 2'h0;
         cpl_data_o  <= 32'h0;
      end else begin
         req_ready_o <= 1'b0;
         cpl_valid_o <= 1'b0;
         unique case (st)
            HRP_S_IDLE: begin
               if (req_valid_i && lnk.link_up && !req_ready_o) begin
                  req_ready_o <= 1'b1;
                  cfg_q       <= req_cfg_i;
                  // RULE7 clear bits 63:36
                  addr_q      <= {28'h0, req_addr_i[35:0]};
                  data_q      <= req_data_i;
                  st          <= HRP_S_SEND;
               end
            end
            HRP_S_SEND: begin
               if (lnk.dn_ready) begin
                  st <= cfg_q ? HRP_S_WAIT : HRP_S_IDLE;
               end
            end
            HRP_S_WAIT: begin
               if (lnk.cpl_valid) begin
                  // RULE10 retry on CRS
                  if (lnk.cpl_status == 2'(hrp_pkg::HRP_CPL_CRS)) begin
                     st <= HRP_S_SEND;
                  // RULE22 no completion after drop
                  end else begin
                     cpl_valid_o  <= ~dropped;
                     cpl_status_o <= lnk.cpl_status;
                     cpl_data_o   <= lnk.cpl_data;
                     st           <= HRP_S_IDLE;
                  end
               end
            end
            default: st <= HRP_S_IDLE;
         endcase
      end
   end

   // RULE4 config offset within 4 KB
   always_comb begin
      lnk.dn_valid = (st == HRP_S_SEND);
      lnk.dn_type  = cfg_q ? 3'(hrp_pkg::HRP_TLP_CFG)
                           : 3'(hrp_pkg::HRP_TLP_MWR);
      lnk.dn_addr  = cfg_q ? {52'h0, addr_q[11:0]} : addr_q;
      lnk.dn_data  = data_q;
   end

   // RULE14 no hot-plug: no presence or slot event logic
   // RULE8 RULE9 RULE11 RULE16 upstream filter
   assign up_above = above_limit(lnk.up_addr);
   always_comb begin
      up_acc = 1'b0;
      if (lnk.up_peer) begin
         up_acc = (lnk.up_type == 3'(hrp_pkg::HRP_TLP_MWR));
      end else if (lnk.up_type == 3'(hrp_pkg::HRP_TLP_MWR) ||
                   lnk.up_type == 3'(hrp_pkg::HRP_TLP_MRD)) begin
         up_acc = ~up_above;
      end else begin
         up_acc = IS_CHIPSET &&
                  (lnk.up_type == 3'(hrp_pkg::HRP_TLP_VLW) ||
                   lnk.up_type == 3'(hrp_pkg::HRP_TLP_RSTWARN) ||
                   lnk.up_type == 3'(hrp_pkg::HRP_TLP_MSI));
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         lnk.up_ready <= 1'b0;
         lnk.ur_valid <= 1'b0;
         core_valid_o <= 1'b0;
         core_type_o  <= 3'h0;
         core_addr_o  <= 64'h0;
         core_data_o  <= 32'h0;
         core_dst_o   <= 2'h0;
      end else begin
         lnk.up_ready <= lnk.up_valid & ~lnk.up_ready;
         core_valid_o <= 1'b0;
         lnk.ur_valid <= 1'b0;
         if (lnk.up_valid && !lnk.up_ready) begin
            core_valid_o <= up_acc;
            // RULE8 UR for high reads
            lnk.ur_valid <= ~lnk.up_peer & up_above &
                            (lnk.up_type == 3'(hrp_pkg::HRP_TLP_MRD));
            core_type_o  <= lnk.up_type;
            core_addr_o  <= lnk.up_addr;
            core_data_o  <= lnk.up_data;
            core_dst_o   <= lnk.up_peer ? 2'(hrp_pkg::HRP_DST_PEER) :
                            (lnk.up_type == 3'(hrp_pkg::HRP_TLP_MWR) ||
                             lnk.up_type == 3'(hrp_pkg::HRP_TLP_MRD)) ?
                            2'(hrp_pkg::HRP_DST_DRAM) :
                            2'(hrp_pkg::HRP_DST_CORE);
         end
      end
   end

   // RULE17 RULE19 RULE20 error sideband
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         lnk.serr     <= 1'b0;
         lnk.smi      <= 1'b0;
         lnk.sci      <= 1'b0;
         lnk.serr_dev <= 5'h00;
      end else begin
         lnk.serr     <= IS_CHIPSET & link_err_i;
         lnk.smi      <= IS_CHIPSET & smi_i;
         lnk.sci      <= IS_CHIPSET & sci_i;
         lnk.serr_dev <= hrp_pkg::SERR_DEV;
      end
   end

   // RULE18 hold handshake
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         hold_req_o   <= 1'b0;
         lnk.hold_ack <= 1'b0;
      end else begin
         hold_req_o   <= IS_CHIPSET & lnk.hold_req;
         lnk.hold_ack <= IS_CHIPSET & lnk.hold_req & hold_grant_i;
      end
   end
endmodule
`default_nettype wire

// [src/hrp_pkg.sv]
// hrp_pkg: shared constants and types for the host root port / chipset link
// assumes: one 25 MHz clock, transaction-level abstraction of both links
`default_nettype none
package hrp_pkg;
   localparam int ADDR_W       = 64;
   localparam int DATA_W       = 32;
   localparam int LIMIT_LSB    = 36;
   localparam int CFG_SPACE_B  = 4096;
   localparam logic [11:0] CFG_EXT_BASE = 12'h100;
   localparam int TRAIN_CYC    = 8;
   localparam logic [4:0] WIDTH_X16 = 5'h10;
   localparam logic [4:0] WIDTH_X8  = 5'h08;
   localparam logic [4:0] WIDTH_X4  = 5'h04;
   localparam logic [4:0] WIDTH_X2  = 5'h02;
   localparam logic [4:0] WIDTH_X1  = 5'h01;
   localparam logic [1:0] CS_LINK_RATE = 2'h1;
   localparam logic [4:0] CS_LINK_WIDTH = 5'h04;
   localparam logic [4:0] SERR_DEV  = 5'h00;

   typedef enum logic [1:0] {
      HRP_RATE_G1,
      HRP_RATE_G2,
      HRP_RATE_G3
   } hrp_rate_t;

   typedef enum logic [2:0] {
      HRP_TLP_MWR,
      HRP_TLP_MRD,
      HRP_TLP_CFG,
      HRP_TLP_VLW,
      HRP_TLP_RSTWARN,
      HRP_TLP_MSI
   } hrp_tlp_t;

   typedef enum logic [1:0] {
      HRP_CPL_SC,
      HRP_CPL_UR,
      HRP_CPL_CRS
   } hrp_cpl_t;

   typedef enum logic [1:0] {
      HRP_DST_CORE,
      HRP_DST_DRAM,
      HRP_DST_PEER
   } hrp_dst_t;
endpackage
`default_nettype wire

// [src/hrp_link_if.sv]
// hrp_link_if: link between the processor end and the far end
// assumes: both ends clocked by core_clk_i; valid held until ready
`default_nettype none
interface hrp_link_if;
   // training
   logic [4:0]  far_width;
   logic [1:0]  far_rate;
   logic        link_up;
   logic [4:0]  neg_width;
   logic [1:0]  neg_rate;
   logic [15:0] rx_pol_inv;
   logic        lane_rev;
   // downstream request
   logic        dn_valid;
   logic        dn_ready;
   logic [2:0]  dn_type;
   logic [63:0] dn_addr;
   logic [31:0] dn_data;
   // downstream completion back up
   logic        cpl_valid;
   logic [1:0]  cpl_status;
   logic [31:0] cpl_data;
   // upstream request
   logic        up_valid;
   logic        up_ready;
   logic [2:0]  up_type;
   logic [63:0] up_addr;
   logic [31:0] up_data;
   logic        up_peer;
   // upstream answer
   logic        ur_valid;
   // sideband
   logic        serr;
   logic        smi;
   logic        sci;
   logic [4:0]  serr_dev;
   logic        hold_req;
   logic        hold_ack;

   modport proc (
      input  far_width, far_rate, dn_ready, cpl_valid, cpl_status, cpl_data,
             up_valid, up_type, up_addr, up_data, up_peer, hold_req,
      output link_up, neg_width, neg_rate, rx_pol_inv, lane_rev,
             dn_valid, dn_type, dn_addr, dn_data, up_ready, ur_valid,
             serr, smi, sci, serr_dev, hold_ack
   );
   modport far (
      output far_width, far_rate, dn_ready, cpl_valid, cpl_status, cpl_data,
             up_valid, up_type, up_addr, up_data, up_peer, hold_req,
      input  link_up, neg_width, neg_rate, rx_pol_inv, lane_rev,
             dn_valid, dn_type, dn_addr, dn_data, up_ready, ur_valid,
             serr, smi, sci, serr_dev, hold_ack
   );
endinterface
`default_nettype wire

// [src/hrp_trainer.sv]
// hrp_trainer: negotiates width and rate after reset
// assumes: far capabilities are stable logic on the same clock
`default_nettype none
module hrp_trainer (
   // clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       rst_i,
   // capabilities
   input  wire logic [4:0] own_width_i,
   input  wire logic [1:0] own_rate_i,
   input  wire logic [4:0] far_width_i,
   input  wire logic [1:0] far_rate_i,
   input  wire logic       retrain_block_i,
   input  wire logic       drop_i,
   // result
   output logic            up_o,
   output logic [4:0]      width_o,
   output logic [1:0]      rate_o
);
   logic [3:0] cnt;
   logic       was_up;

   function automatic logic [4:0] pick_width(input logic [4:0] a,
                                             input logic [4:0] b);
      logic [4:0] m;
      m = (a < b) ? a : b;
      if (m >= hrp_pkg::WIDTH_X16)     pick_width = hrp_pkg::WIDTH_X16;
      else if (m >= hrp_pkg::WIDTH_X8) pick_width = hrp_pkg::WIDTH_X8;
      else if (m >= hrp_pkg::WIDTH_X4) pick_width = hrp_pkg::WIDTH_X4;
      else if (m >= hrp_pkg::WIDTH_X2) pick_width = hrp_pkg::WIDTH_X2;
      else                             pick_width = hrp_pkg::WIDTH_X1;
   endfunction

   // RULE12 train out of reset
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cnt    <= 4'h0;
         up_o   <= 1'b0;
         was_up <= 1'b0;
      end else if (drop_i) begin
         up_o   <= 1'b0;
         cnt    <= 4'h0;
      end else if (!up_o && !(was_up && retrain_block_i)) begin
         if (cnt == 4'(hrp_pkg::TRAIN_CYC - 1)) begin
            up_o   <= 1'b1;
            was_up <= 1'b1;
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end

   // RULE1 RULE2 width and rate
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         width_o <= 5'h00;
         rate_o  <= 2'h0;
      end else if (!up_o) begin
         width_o <= pick_width(own_width_i, far_width_i);
         rate_o  <= (own_rate_i < far_rate_i) ? own_rate_i : far_rate_i;
      end
   end
endmodule
`default_nettype wire

// [src/hrp_far_end.sv]
// hrp_far_end: partner end (endpoint or companion hub) of a link
// assumes: joined through hrp_link_if.far; user side is same-clock
`default_nettype none
module hrp_far_end (
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   // link
   hrp_link_if.far          lnk,
   // capabilities
   input  wire logic [4:0]  cap_width_i,
   input  wire logic [1:0]  cap_rate_i,
   // downstream delivery and answer
   output logic             dn_seen_o,
   output logic [2:0]       dn_type_o,
   output logic [63:0]      dn_addr_o,
   output logic [31:0]      dn_data_o,
   input  wire logic        ans_valid_i,
   input  wire logic [1:0]  ans_status_i,
   input  wire logic [31:0] ans_data_i,
   // upstream request
   input  wire logic        up_valid_i,
   input  wire logic [2:0]  up_type_i,
   input  wire logic [63:0] up_addr_i,
   input  wire logic [31:0] up_data_i,
   input  wire logic        up_peer_i,
   output logic             up_done_o,
   output logic             ur_seen_o,
   // sideband
   input  wire logic        hold_i,
   output logic             hold_ack_o,
   output logic             serr_o
);
   logic up_pend;

   // RULE12 RULE1 RULE2 advertise capabilities
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         lnk.far_width <= 5'h00;
         lnk.far_rate  <= 2'h0;
      end else begin
         lnk.far_width <= cap_width_i;
         lnk.far_rate  <= cap_rate_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         lnk.dn_ready   <= 1'b0;
         dn_seen_o      <= 1'b0;
         dn_type_o      <= 3'h0;
         dn_addr_o      <= 64'h0;
         dn_data_o      <= 32'h0;
         lnk.cpl_valid  <= 1'b0;
         lnk.cpl_status <= 2'h0;
         lnk.cpl_data   <= 32'h0;
      end else begin
         lnk.dn_ready <= lnk.dn_valid & ~lnk.dn_ready;
         dn_seen_o    <= lnk.dn_valid & ~lnk.dn_ready;
         if (lnk.dn_valid && !lnk.dn_ready) begin
            dn_type_o <= lnk.dn_type;
            dn_addr_o <= lnk.dn_addr;
            dn_data_o <= lnk.dn_data;
         end
         lnk.cpl_valid  <= ans_valid_i;
         lnk.cpl_status <= ans_status_i;
         lnk.cpl_data   <= ans_data_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         up_pend      <= 1'b0;
         lnk.up_valid <= 1'b0;
         lnk.up_type  <= 3'h0;
         lnk.up_addr  <= 64'h0;
         lnk.up_data  <= 32'h0;
         lnk.up_peer  <= 1'b0;
         up_done_o    <= 1'b0;
      end else begin
         up_done_o <= 1'b0;
         // done blocks a retake while the requester still holds valid
         if (!up_pend && !up_done_o && up_valid_i && lnk.link_up) begin
            up_pend      <= 1'b1;
            lnk.up_valid <= 1'b1;
            lnk.up_type  <= up_type_i;
            lnk.up_addr  <= up_addr_i;
            lnk.up_data  <= up_data_i;
            lnk.up_peer  <= up_peer_i;
         end else if (up_pend && lnk.up_ready) begin
            up_pend      <= 1'b0;
            lnk.up_valid <= 1'b0;
            up_done_o    <= 1'b1;
         end
      end
   end

   // RULE18 hold request
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         lnk.hold_req <= 1'b0;
         hold_ack_o   <= 1'b0;
         ur_seen_o    <= 1'b0;
         serr_o       <= 1'b0;
      end else begin
         lnk.hold_req <= hold_i;
         hold_ack_o   <= lnk.hold_ack;
         ur_seen_o    <= lnk.ur_valid;
         serr_o       <= lnk.serr;
      end
   end
endmodule
`default_nettype wire

// [verification/hrp_props.sv]
// hrp_props: assertions on the link between processor end and far end
// assumes: instantiated beside hrp_link_if, single core_clk_i domain
`default_nettype none
module hrp_props (
   // clock and reset
   input wire logic        core_clk_i,
   input wire logic        rst_i,
   // training
   input wire logic        link_up,
   input wire logic [4:0]  neg_width,
   input wire logic [1:0]  neg_rate,
   input wire logic [4:0]  far_width,
   // transfers
   input wire logic        dn_valid,
   input wire logic        dn_ready,
   input wire logic [63:0] dn_addr,
   input wire logic        cpl_valid,
   input wire logic [1:0]  cpl_status,
   input wire logic        up_valid,
   input wire logic [2:0]  up_type,
   input wire logic [63:0] up_addr,
   input wire logic        ur_valid,
   input wire logic [4:0]  serr_dev
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   addr_top_zero_a: assert property (
      dn_valid |-> dn_addr[63:36] == 28'h0000000)
      else $error("downstream address above limit");
   width_legal_a: assert property (
      link_up |-> neg_width inside {5'h10, 5'h08, 5'h04, 5'h02, 5'h01})
      else $error("negotiated width not legal");
   width_fits_a: assert property (
      link_up |-> neg_width <= far_width)
      else $error("negotiated width above partner width");
   rate_legal_a: assert property (
      link_up |-> neg_rate != 2'h3)
      else $error("negotiated rate not legal");
   train_auto_a: assert property (
      $fell(rst_i) |-> ##[1:20] link_up)
      else $error("link did not train after reset");
   req_hold_a: assert property (
      dn_valid && !dn_ready |=> dn_valid && $stable(dn_addr))
      else $error("downstream request dropped before ready");
   cfg_retry_a: assert property (
      cpl_valid && cpl_status == 2'h2 |=> dn_valid)
      else $error("retry status not reissued");
   high_read_ur_a: assert property (
      $rose(up_valid) && up_type == 3'h1 && up_addr[63:36] != 28'h0
      && link_up |-> ##[1:10] ur_valid)
      else $error("high upstream read not refused");
   serr_dev_zero_a: assert property (
      serr_dev == 5'h00)
      else $error("error attributed to wrong device");
endmodule
`default_nettype wire

// [verification/host_root_port_and_chipset_link_tb.sv]
// host_root_port_and_chipset_link_tb: both link ends joined back to back
// assumes: processor end in root port mode, far end as its partner
`default_nettype none
module host_root_port_and_chipset_link_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RW = 103;
   logic core_clk_i, rst_i, req_valid, req_cfg, req_ready, cpl_v, core_v;
   logic hold, hold_ack, hold_grant, hold_req, serr, link_down, coding;
   logic dn_seen, ans_v, up_v, up_peer, up_done, ur_seen, lane_rev;
   logic [63:0] req_addr, core_ad, dn_ad, up_ad, a;
   logic [31:0] req_data, cpl_dat, core_da, dn_da, ans_da, up_da, d;
   logic [2:0] core_ty, dn_ty, up_ty;
   logic [1:0] cpl_st, core_dst, ans_st, cap_rate;
   logic [4:0] cap_width;
   logic [15:0] pol_inv;
   logic [RW-1:0] exp_q[$];
   int errors, samples_checked, crs_left;
   hrp_link_if lnk ();
   // root port: link errors tied off, hub retrain block idle
   hrp_proc_end #(.IS_CHIPSET(1'b0)) u_hrp_proc_end (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .lnk(lnk),
      .pol_inv_i(pol_inv), .lane_rev_i(lane_rev),
      .req_valid_i(req_valid), .req_cfg_i(req_cfg), .req_addr_i(req_addr),
      .req_data_i(req_data), .req_ready_o(req_ready), .cpl_valid_o(cpl_v),
      .cpl_status_o(cpl_st), .cpl_data_o(cpl_dat), .core_valid_o(core_v),
      .core_type_o(core_ty), .core_addr_o(core_ad), .core_data_o(core_da),
      .core_dst_o(core_dst), .smi_i(1'b0), .sci_i(1'b0), .link_err_i(1'b0),
      .hold_grant_i(hold_grant), .hold_req_o(hold_req),
      .link_down_o(link_down), .coding_130_o(coding));
   hrp_far_end u_hrp_far_end (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .lnk(lnk),
      .cap_width_i(cap_width), .cap_rate_i(cap_rate), .dn_seen_o(dn_seen),
      .dn_type_o(dn_ty), .dn_addr_o(dn_ad), .dn_data_o(dn_da),
      .ans_valid_i(ans_v), .ans_status_i(ans_st), .ans_data_i(ans_da),
      .up_valid_i(up_v), .up_type_i(up_ty), .up_addr_i(up_ad),
      .up_data_i(up_da), .up_peer_i(up_peer), .up_done_o(up_done),
      .ur_seen_o(ur_seen), .hold_i(hold), .hold_ack_o(hold_ack),
      .serr_o(serr));
   hrp_props u_hrp_props (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .link_up(lnk.link_up),
      .neg_width(lnk.neg_width), .neg_rate(lnk.neg_rate),
      .far_width(lnk.far_width), .dn_valid(lnk.dn_valid),
      .dn_ready(lnk.dn_ready), .dn_addr(lnk.dn_addr),
      .cpl_valid(lnk.cpl_valid), .cpl_status(lnk.cpl_status),
      .up_valid(lnk.up_valid), .up_type(lnk.up_type),
      .up_addr(lnk.up_addr), .ur_valid(lnk.ur_valid),
      .serr_dev(lnk.serr_dev));

   initial begin
      core_clk_i = 1'b0;
      forever #20 core_clk_i = ~core_clk_i;
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [RW-1:0] seen,
                        input logic [RW-1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tick(input int n = 1);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask

   task automatic drain();
      for (int n = 0; n < 60 && exp_q.size() > 0; n++) tick();
      tick(3);
   endtask

   // results seen at either end are matched oldest first
   task automatic take(input logic [RW-1:0] seen);
      logic [RW-1:0] e;
      // high-z never matches a driven result, nor an unknown one
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 'z;
      check("event", seen, e);
   endtask

   always @(posedge core_clk_i) begin
      if (rst_i === 1'b0) begin
         if (dn_seen === 1'b1) take({2'h1, dn_ty, 2'h0, dn_ad, dn_da});
         if (core_v === 1'b1) take({2'h2, core_ty, core_dst, core_ad, core_da});
         if (cpl_v === 1'b1) take({3'h6, cpl_st, 66'h0, cpl_dat});
         if (ur_seen === 1'b1) take('0);
      end
   end

   // partner answers config cycles, with retry status while crs_left lasts
   always @(posedge core_clk_i) begin
      if (dn_seen === 1'b1 && dn_ty === 3'(hrp_pkg::HRP_TLP_CFG)) begin
         #1 ans_v = 1'b1;
         ans_st = (crs_left > 0) ? 2'(hrp_pkg::HRP_CPL_CRS) : 2'h0;
         crs_left--;
         @(posedge core_clk_i);
         #1 ans_v = 1'b0;
      end
   end

   task automatic creq(input logic cfg, input logic [63:0] ad,
                       input logic [31:0] dat);
      req_valid = 1'b1;
      req_cfg = cfg;
      req_addr = ad;
      req_data = dat;
      for (int n = 0; n < 40; n++) begin
         @(posedge core_clk_i);
         if (req_ready === 1'b1) break;
      end
      #1 req_valid = 1'b0;
      drain();
   endtask

   task automatic ureq(input logic [2:0] ty, input logic [63:0] ad,
                       input logic [31:0] dat, input logic peer);
      up_v = 1'b1;
      up_ty = ty;
      up_ad = ad;
      up_da = dat;
      up_peer = peer;
      for (int n = 0; n < 20; n++) begin
         @(posedge core_clk_i);
         if (up_done === 1'b1 || ur_seen === 1'b1) break;
      end
      #1 up_v = 1'b0;
      drain();
   endtask

   initial begin
      #(5000 * 40);
      errors++;
      close_out();
   end

   initial begin
      logic [4:0] wt[7];
      logic [4:0] ew;
      logic [2:0] ty;
      wt = '{5'h08, 5'h04, 5'h02, 5'h01, 5'h0C, 5'h03, 5'h10};
      {req_valid, req_cfg, req_addr, req_data, hold, hold_grant} = '0;
      {ans_v, ans_st, ans_da, up_v, up_ty, up_ad, up_da, up_peer} = '0;
      {cap_width, cap_rate, pol_inv, lane_rev, crs_left} = '0;
      rst_i = 1'b1;
      void'($urandom(32'h9aa0f679));
      foreach (wt[i]) begin
         cap_width = wt[i];
         cap_rate = 2'($urandom_range(2));
         pol_inv = 16'($urandom);
         lane_rev = 1'($urandom);
         rst_i = 1'b1;
         tick(5);
         rst_i = 1'b0;
         for (int n = 0; n < 40 && lnk.link_up !== 1'b1; n++) tick();
         ew = wt[i] >= 16 ? 5'h10 : wt[i] >= 8 ? 5'h08 : wt[i] >= 4 ? 5'h04 :
              wt[i] >= 2 ? 5'h02 : 5'h01;
         tick();
         check("width", RW'(lnk.neg_width), RW'(ew));
         check("rate", RW'(lnk.neg_rate), RW'(cap_rate));
         check("coding", RW'(coding), RW'(cap_rate == 2'h2));
         check("lanes", RW'({lnk.lane_rev, lnk.rx_pol_inv}),
               RW'({lane_rev, pol_inv}));
      end
      repeat (2) begin
         a = {32'($urandom), 32'($urandom)} | 64'hF000_0000_0000_0000;
         d = 32'($urandom);
         exp_q.push_back({5'h8, 2'h0, 28'h0, a[35:0], d});
         creq(1'b0, a, d);
      end
      foreach (wt[i]) begin
         if (i < 2) begin
            a = {32'($urandom), 32'($urandom)};
            a[11:0] = (i == 0) ? 12'h100 : 12'hFFC;
            d = 32'($urandom);
            ans_da = 32'($urandom);
            crs_left = 2 - i;
            repeat (3 - i) exp_q.push_back({5'hA, 54'h0, a[11:0], d});
            exp_q.push_back({3'h6, 2'h0, 66'h0, ans_da});
            creq(1'b1, a, d);
         end
      end
      for (int k = 0; k < 5; k++) begin
         ty = (k == 0) ? 3'(hrp_pkg::HRP_TLP_VLW) :
              (k == 1) ? 3'(hrp_pkg::HRP_TLP_RSTWARN) :
              (k == 2) ? 3'(hrp_pkg::HRP_TLP_MSI) : 3'h0;
         a = {28'h0, 4'($urandom), 32'($urandom & 32'hFFFF_FFFC)};
         d = 32'($urandom);
         // root port drops core messages; only the peer write goes out
         if (k == 3) exp_q.push_back({2'h2, ty, 2'h2, a, d});
         if (k < 4) ureq(ty, a, d, k == 3);
      end
      ureq(3'(hrp_pkg::HRP_TLP_MRD), a, d, 1'b1);
      a[40] = 1'b1;
      ureq(3'(hrp_pkg::HRP_TLP_MWR), a, d, 1'b0);
      exp_q.push_back('0);
      ureq(3'(hrp_pkg::HRP_TLP_MRD), a, d, 1'b0);
      // the hold handshake belongs to the chipset link, not a root port
      hold = 1'b1;
      tick(4);
      check("hold_req", RW'(hold_req), RW'(0));
      hold_grant = 1'b1;
      tick(4);
      check("hold_ack", RW'(hold_ack), RW'(0));
      {hold, hold_grant} = 2'b00;
      tick(4);
      check("hold_end", RW'({hold_req, hold_ack}), RW'(0));
      check("pending", RW'(exp_q.size()), RW'(0));
      close_out();
   end
endmodule
`default_nettype wire
